// file: mcu_bus_host_pkg.sv
// Function
// - Non-muxed 8-bit: address on sixteen pins, data byte on Port A.
// - Non-muxed 16-bit: low data on Port A, high data on Port B.
// - Address bits 16 to 18 on Port C, bit 19 on shared pin.
// - Other-line muxed hosts use non-muxed wiring, still give latch strobe.
package mcu_bus_host_pkg;
  // Bus modes
  localparam logic [1:0] MODE_MUX8   = 2'h0;
  localparam logic [1:0] MODE_MUX16  = 2'h1;
  localparam logic [1:0] MODE_NMUX8  = 2'h2;
  localparam logic [1:0] MODE_NMUX16 = 2'h3;
  // Register offsets of the host's own command port
  localparam logic [3:0] REG_CTRL    = 4'h0;
  localparam logic [3:0] REG_ADDR    = 4'h1;
  localparam logic [3:0] REG_WDATA   = 4'h2;
  localparam logic [3:0] REG_RDATA   = 4'h3;
  localparam logic [3:0] REG_STATUS  = 4'h4;
  localparam logic [3:0] REG_CMD     = 4'h5;
  // Control field positions
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_POL_BIT  = 2;
  localparam int CTRL_CHIPSEL_BIT = 3;
  localparam int CTRL_BYTEHI_BIT  = 4;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  // Command bits
  localparam int CMD_WRITE_BIT = 0;
  localparam int CMD_READ_BIT  = 1;
  // Phase lengths in ns and derived cycles at 125 MHz
  localparam int CLK_PERIOD_PS  = 8000;
  localparam int ADDR_SETUP_NS  = 16;
  localparam int LATCH_NS       = 24;
  localparam int STROBE_NS      = 48;
  localparam int HOLD_NS        = 16;
  localparam int ADDR_SETUP_CYC = (ADDR_SETUP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int LATCH_CYC      = (LATCH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int STROBE_CYC     = (STROBE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int HOLD_CYC       = (HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CNT_W          = 4;
endpackage

// file: mcu_phase_timer.sv
`timescale 1ns/1ps
// Down counter that pulses done after a loaded number of cycles
module mcu_phase_timer #(
  parameter int W = 4
) (
  // Clock and reset
  input  wire logic         mclk_in,
  input  wire logic         rst_in,
  // Control
  input  wire logic         load_in,
  input  wire logic [W-1:0] count_in,
  // Status
  output logic              done_out
);
  logic [W-1:0] cnt_reg;
  logic         run_reg;

  // Count down while running; load wins over an ongoing count
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_reg <= '0;
      run_reg <= 1'b0;
    end else if (load_in) begin
      cnt_reg <= count_in;
      run_reg <= 1'b1;
    end else if (run_reg) begin
      cnt_reg <= cnt_reg - 1'b1;
      if (cnt_reg == W'(1)) begin
        run_reg <= 1'b0;
      end
    end
  end

  // Done ignores load: the sequencer reloads on done, a load term would close a loop
  assign done_out = run_reg && (cnt_reg == W'(1));
endmodule

// file: mcu_bus_host.sv
// Decided for this implementation: the register addresses and the plain strobed port.
`timescale 1ns/1ps
// Host side bus master that drives the peripheral through its pins
module mcu_bus_host (
  // Clock and reset
  input  wire logic        mclk_in,
  input  wire logic        rst_in,
  // Command port
  input  wire logic [3:0]  addr_in,
  input  wire logic [31:0] wdata_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  output logic [31:0]      rdata_out,
  // Low address/data byte pins
  input  wire logic [7:0]  low_addr_data_byte_in,
  output logic [7:0]       low_addr_data_byte_out,
  output logic             low_addr_data_byte_oe_out,
  // High address/data byte pins
  input  wire logic [7:0]  high_addr_data_byte_in,
  output logic [7:0]       high_addr_data_byte_out,
  output logic             high_addr_data_byte_oe_out,
  // Port A data byte in non-muxed modes
  input  wire logic [7:0]  porta_data_in,
  output logic [7:0]       porta_data_out,
  output logic             porta_data_oe_out,
  // Port B upper data byte in non-muxed 16-bit mode
  input  wire logic [7:0]  portb_pins_in,
  output logic [7:0]       portb_pins_out,
  output logic             portb_pins_oe_out,
  // Upper address and control
  output logic [2:0]       portc_pins_out,
  output logic             addr19_or_chip_sel_in_out,
  output logic             addr_latch_strobe_out,
  output logic             byte_high_enable_n_out,
  output logic             read_n_out,
  output logic             write_n_out
);
  import mcu_bus_host_pkg::*;

  typedef enum {ST_IDLE, ST_SETUP, ST_LATCH, ST_GAP, ST_STROBE, ST_HOLD} state_t;

  state_t      state_reg, state_next;
  logic [31:0] ctrl_reg;
  logic [19:0] addr_reg;
  logic [15:0] wdata_reg;
  logic [15:0] rdata_reg;
  logic        is_read_reg;
  logic        busy;
  logic        done_reg;
  logic        tmr_load;
  logic [CNT_W-1:0] tmr_count;
  logic        tmr_done;

  // Decoded configuration
  wire [1:0] mode      = ctrl_reg[CTRL_MODE_LSB +: 2];
  wire       latch_pol = ctrl_reg[CTRL_POL_BIT];
  wire       cs_in_en  = ctrl_reg[CTRL_CHIPSEL_BIT];
  wire       upper_en  = ctrl_reg[CTRL_BYTEHI_BIT];
  wire       muxed     = (mode == MODE_MUX8) || (mode == MODE_MUX16);
  wire       wide      = (mode == MODE_MUX16) || (mode == MODE_NMUX16);
  wire       go_wr     = wr_in && (addr_in == REG_CMD) && wdata_in[CMD_WRITE_BIT] && !busy;
  wire       go_rd     = wr_in && (addr_in == REG_CMD) && wdata_in[CMD_READ_BIT] && !busy
                         && !wdata_in[CMD_WRITE_BIT];
  wire       in_strobe = (state_reg == ST_STROBE);
  wire       addr_ph   = (state_reg == ST_SETUP) || (state_reg == ST_LATCH);
  // Address stays out through the gap: the device latch closes on the strobe's
  // trailing edge and needs the address held past it
  wire       data_ph   = in_strobe || (state_reg == ST_HOLD);
  wire       host_wdrv = data_ph && !is_read_reg;

  assign busy = (state_reg != ST_IDLE);

  mcu_phase_timer #(.W(CNT_W)) u_timer (
    .mclk_in  (mclk_in),
    .rst_in   (rst_in),
    .load_in  (tmr_load),
    .count_in (tmr_count),
    .done_out (tmr_done)
  );

  // Bus cycle sequencer
  always_comb begin
    state_next = state_reg;
    tmr_load   = 1'b0;
    tmr_count  = CNT_W'(ADDR_SETUP_CYC);
    case (state_reg)
      ST_IDLE: begin
        if (go_wr || go_rd) begin
          state_next = ST_SETUP;
          tmr_load   = 1'b1;
        end
      end
      ST_SETUP: begin
        if (tmr_done) begin
          state_next = ST_LATCH;
          tmr_load   = 1'b1;
          tmr_count  = CNT_W'(LATCH_CYC);
        end
      end
      ST_LATCH: begin
        if (tmr_done) begin
          state_next = ST_GAP;
        end
      end
      ST_GAP: begin
        state_next = ST_STROBE;
        tmr_load   = 1'b1;
        tmr_count  = CNT_W'(STROBE_CYC);
      end
      ST_STROBE: begin
        if (tmr_done) begin
          state_next = ST_HOLD;
          tmr_load   = 1'b1;
          tmr_count  = CNT_W'(HOLD_CYC);
        end
      end
      ST_HOLD: begin
        if (tmr_done) begin
          state_next = ST_IDLE;
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  // State and command registers
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      state_reg   <= ST_IDLE;
      ctrl_reg    <= CTRL_RESET;
      addr_reg    <= '0;
      wdata_reg   <= '0;
      is_read_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      // Config changes mid-cycle would corrupt pin roles, so ignore them
      if (wr_in && !busy && addr_in == REG_CTRL) ctrl_reg <= wdata_in;
      if (wr_in && !busy && addr_in == REG_ADDR) addr_reg <= wdata_in[19:0];
      if (wr_in && !busy && addr_in == REG_WDATA) wdata_reg <= wdata_in[15:0];
      if (go_wr || go_rd) is_read_reg <= go_rd;
    end
  end

  // Sample device data at the end of the read strobe
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_reg <= '0;
      done_reg  <= 1'b0;
    end else begin
      if (in_strobe && tmr_done && is_read_reg) begin
        if (muxed) begin
          rdata_reg[7:0]  <= low_addr_data_byte_in;
          rdata_reg[15:8] <= wide ? high_addr_data_byte_in : 8'h00;
        end else begin
          rdata_reg[7:0]  <= porta_data_in;
          rdata_reg[15:8] <= wide ? portb_pins_in : 8'h00;
        end
      end
      if (go_wr || go_rd) begin
        done_reg <= 1'b0;
      end else if (state_reg == ST_HOLD && tmr_done) begin
        done_reg <= 1'b1;
      end
    end
  end

  // Register read mux, answered one cycle later
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_out <= '0;
    end else if (rd_in) begin
      case (addr_in)
        REG_CTRL:   rdata_out <= ctrl_reg;
        REG_ADDR:   rdata_out <= {12'h000, addr_reg};
        REG_WDATA:  rdata_out <= {16'h0000, wdata_reg};
        REG_RDATA:  rdata_out <= {16'h0000, rdata_reg};
        REG_STATUS: rdata_out <= {30'h0, done_reg, busy};
        default:    rdata_out <= 32'h0000_0000;
      endcase
    end else begin
      rdata_out <= 32'h0000_0000;
    end
  end

  // Address and data pins: muxed puts address first, data after
  always_comb begin
    low_addr_data_byte_out     = addr_reg[7:0];
    low_addr_data_byte_oe_out  = busy && !(muxed && data_ph && is_read_reg);
    high_addr_data_byte_out    = addr_reg[15:8];
    high_addr_data_byte_oe_out = busy && !(mode == MODE_MUX16 && data_ph && is_read_reg);
    if (muxed && data_ph) begin
      low_addr_data_byte_out = wdata_reg[7:0];
      if (mode == MODE_MUX16) begin
        high_addr_data_byte_out = wdata_reg[15:8];
      end
    end
  end

  // Data ports in non-muxed wiring
  assign porta_data_out    = wdata_reg[7:0];
  assign porta_data_oe_out = host_wdrv && !muxed;
  assign portb_pins_out    = wdata_reg[15:8];
  assign portb_pins_oe_out = host_wdrv && (mode == MODE_NMUX16);

  // Upper address and strobes
  assign portc_pins_out = addr_reg[18:16];
  // With chip select use, high between cycles powers the device down
  assign addr19_or_chip_sel_in_out = cs_in_en ? !busy : addr_reg[19];
  // Latch strobe in every mode, also for non-muxed wiring
  assign addr_latch_strobe_out = latch_pol ^ !(state_reg == ST_LATCH);
  assign byte_high_enable_n_out = !(busy && wide && upper_en);
  assign read_n_out  = !(in_strobe && is_read_reg);
  assign write_n_out = !(in_strobe && !is_read_reg);

  // Address must not move while latch strobe is active
  chk_addr_stable: assert property (@(posedge mclk_in) disable iff (rst_in)
    (state_reg == ST_LATCH) |-> $stable(addr_reg))
    else $error("address moved during latch");
  // No host drive of the low address/data pins during a muxed read strobe
  chk_no_contention: assert property (@(posedge mclk_in) disable iff (rst_in)
    (!read_n_out && muxed) |-> !low_addr_data_byte_oe_out)
    else $error("host drives pins during read");
  // Strobe never active during address phase
  chk_strobe_phase: assert property (@(posedge mclk_in) disable iff (rst_in)
    addr_ph |-> (read_n_out && write_n_out))
    else $error("strobe during address phase");
  // Port B drives only in a data phase or a non-muxed 16-bit write strobe
  chk_portb_role: assert property (@(posedge mclk_in) disable iff (rst_in)
    portb_pins_oe_out |-> (mode == MODE_NMUX16 && !write_n_out || data_ph))
    else $error("port b driven outside mode");
  // A started cycle finishes within a bounded time
  chk_cycle_ends: assert property (@(posedge mclk_in) disable iff (rst_in)
    $rose(busy) |-> ##[4:30] !busy)
    else $error("bus cycle did not finish");
  // Non-muxed: low byte pins keep the address
  chk_nmux_addr: assert property (@(posedge mclk_in) disable iff (rst_in)
    (busy && !muxed) |-> (low_addr_data_byte_out == addr_reg[7:0]))
    else $error("low byte not address");
  // Chip select input follows idle state when enabled
  chk_csi_idle: assert property (@(posedge mclk_in) disable iff (rst_in)
    (cs_in_en && !busy) |-> addr19_or_chip_sel_in_out)
    else $error("chip select not high at idle");
  // Write strobe lasts the programmed count
  chk_wr_width: assert property (@(posedge mclk_in) disable iff (rst_in)
    $fell(write_n_out) |-> !write_n_out [*6] ##1 write_n_out)
    else $error("write strobe width wrong");
endmodule

// file: mcu_dev_model.sv
`timescale 1ns/1ps
// Behavioural peripheral as seen from the host pins
module mcu_dev_model #(
  // Port B direction bits for its I/O role; value arbitrary
  parameter logic [7:0] PB_DIR = 8'ha5
) (
  // Host pins
  input  wire logic [7:0]  lo_in,
  input  wire logic [7:0]  hi_in,
  input  wire logic [7:0]  pa_in,
  input  wire logic [7:0]  pb_in,
  input  wire logic [2:0]  pc_in,
  input  wire logic        top_addr_in,
  input  wire logic        latch_in,
  input  wire logic        rd_n_in,
  input  wire logic        wr_n_in,
  // Configuration
  input  wire logic [1:0]  mode_in,
  input  wire logic        pol_in,
  input  wire logic        cs_in_en_in,
  // Device drivers and captured values
  output logic [7:0]       lo_data_out,
  output logic [7:0]       hi_data_out,
  output logic             lo_oe_out,
  output logic             hi_oe_out,
  output logic             pa_oe_out,
  output logic             pb_oe_out,
  output logic [19:0]      addr_out,
  output logic [15:0]      wdata_out,
  // Decoder outputs
  output logic [7:0]       cs_n_out,
  output logic             pc_term_out,
  output logic [7:0]       pb_dir_out
);
  // Mode decode and selection
  wire act = ~(latch_in ^ pol_in);
  wire sel = ~(cs_in_en_in & top_addr_in);
  wire mux = ~mode_in[1];
  wire wide = mode_in[0];
  wire drv = sel & ~rd_n_in;
  // Trailing edge of the strobe closes the transparent latch
  always @(negedge act) addr_out = {top_addr_in, pc_in, hi_in, lo_in};
  // One-hot product terms from latched address bits 15 and 14
  wire [3:0] term = 4'h1 << addr_out[15:14];
  // Chip selects: up to four terms on each low pin, up to two on each high pin
  assign cs_n_out = sel ? ~{term[3] | term[2], term[1] | term[0], term[3], term[2],
                            |term, term[3] | term[2], term[1], term[0]} : 8'hff;
  // One product term for the Port C output role
  assign pc_term_out = sel & (addr_out[19:16] == 4'hf);
  // Port B I/O direction bits, unless Port B carries upper data
  assign pb_dir_out = (mux | ~wide) ? PB_DIR : 8'h00;
  // Read data is a fixed scramble of the address, easy to predict
  assign lo_data_out = addr_out[7:0] ^ 8'h3c;
  assign hi_data_out = addr_out[15:8] ^ 8'hc3;
  assign lo_oe_out = drv & mux;
  assign hi_oe_out = drv & mux & wide;
  assign pa_oe_out = drv & ~mux;
  assign pb_oe_out = drv & ~mux & wide;
  // Write data taken at the rising write strobe
  always @(posedge wr_n_in) if (sel) wdata_out = mux ? {hi_in, lo_in} : {pb_in, pa_in};
endmodule

// file: mcu_bus_host_tb.sv
`timescale 1ns/1ps
module mcu_bus_host_tb;
  import mcu_bus_host_pkg::*;
  logic        mclk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic        wr_in = 1'b0;
  logic        rd_in = 1'b0;
  logic [3:0]  addr_in = 4'h0;
  logic [31:0] wdata_in = 32'h0;
  logic [31:0] rdata_out, d;
  logic [7:0]  h_lo, h_hi, h_pa, h_pb, d_lo, d_hi, lo_w, hi_w, pa_w, pb_w;
  logic        h_lo_oe, h_hi_oe, h_pa_oe, h_pb_oe, lo_oe, hi_oe, pa_oe, pb_oe;
  logic        top_a, latch_s, bhe_n, rd_n, wr_n, pc_t;
  logic        cs_en = 1'b0;
  logic [7:0]  cs_n, pb_dir;
  logic [2:0]  pc;
  logic [1:0]  mode = 2'h0;
  logic        pol = 1'b0;
  logic [19:0] dev_addr;
  logic [15:0] dev_wdata;
  int          bad_count = 0;
  int          tests_run = 0;
  always #4 mclk_in = ~mclk_in;
  // Resolved pin levels; pulled up when nobody drives
  assign lo_w = h_lo_oe ? h_lo : lo_oe ? d_lo : 8'hff;
  assign hi_w = h_hi_oe ? h_hi : hi_oe ? d_hi : 8'hff;
  assign pa_w = h_pa_oe ? h_pa : pa_oe ? d_lo : 8'hff;
  assign pb_w = h_pb_oe ? h_pb : pb_oe ? d_hi : 8'hff;
  mcu_bus_host u_dut (.mclk_in(mclk_in), .rst_in(rst_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .low_addr_data_byte_in(lo_w), .low_addr_data_byte_out(h_lo),
    .low_addr_data_byte_oe_out(h_lo_oe), .high_addr_data_byte_in(hi_w),
    .high_addr_data_byte_out(h_hi), .high_addr_data_byte_oe_out(h_hi_oe),
    .porta_data_in(pa_w), .porta_data_out(h_pa), .porta_data_oe_out(h_pa_oe),
    .portb_pins_in(pb_w), .portb_pins_out(h_pb), .portb_pins_oe_out(h_pb_oe),
    .portc_pins_out(pc), .addr19_or_chip_sel_in_out(top_a), .addr_latch_strobe_out(latch_s),
    .byte_high_enable_n_out(bhe_n), .read_n_out(rd_n), .write_n_out(wr_n));
  mcu_dev_model u_dev (.lo_in(lo_w), .hi_in(hi_w), .pa_in(pa_w), .pb_in(pb_w),
    .pc_in(pc), .top_addr_in(top_a), .latch_in(latch_s), .rd_n_in(rd_n), .wr_n_in(wr_n),
    .mode_in(mode), .pol_in(pol), .cs_in_en_in(cs_en), .lo_data_out(d_lo),
    .hi_data_out(d_hi), .lo_oe_out(lo_oe), .hi_oe_out(hi_oe), .pa_oe_out(pa_oe),
    .pb_oe_out(pb_oe), .addr_out(dev_addr), .wdata_out(dev_wdata), .cs_n_out(cs_n),
    .pc_term_out(pc_t), .pb_dir_out(pb_dir));
  task automatic print_verdict;
    if (bad_count == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // Command port cycles, one strobe cycle each
  task automatic reg_wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge mclk_in);
    addr_in <= a;
    wdata_in <= v;
    wr_in <= 1'b1;
    @(posedge mclk_in);
    wr_in <= 1'b0;
  endtask
  task automatic reg_rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge mclk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge mclk_in);
    rd_in <= 1'b0;
    #1 v = rdata_out;
  endtask
  // Poll status with a bound; a stuck cycle ends the run
  task automatic wait_done;
    int n;
    n = 0;
    do begin
      reg_rd(REG_STATUS, d);
      n++;
    end while (d[1] !== 1'b1 && n < 40);
    if (d[1] !== 1'b1) begin
      check(d, 32'h2, "done timeout");
      print_verdict;
    end
  endtask
  // One pin-level transfer; an address write while busy must be ignored
  task automatic xfer(input logic [1:0] m, input logic p, input logic is_rd,
                      input logic [19:0] a, input logic [15:0] w);
    logic [31:0] msk;
    msk = m[0] ? 32'hffff : 32'h00ff;
    mode = m;
    pol = p;
    reg_wr(REG_CTRL, {29'h0, p, m});
    reg_wr(REG_ADDR, {12'h0, a});
    reg_wr(REG_WDATA, {16'h0, w});
    reg_wr(REG_CMD, is_rd ? 32'h2 : 32'h1);
    reg_wr(REG_ADDR, {12'h0, ~a});
    wait_done;
    check({12'h0, dev_addr}, {12'h0, a}, "latched address");
    if (is_rd) begin
      reg_rd(REG_RDATA, d);
      check(d & msk, {16'h0, a[15:8] ^ 8'hc3, a[7:0] ^ 8'h3c} & msk, "read data");
    end else begin
      check({16'h0, dev_wdata} & msk, {16'h0, w} & msk, "write data");
    end
    check({h_lo_oe, h_hi_oe, h_pa_oe, h_pb_oe}, 32'h0, "idle drive");
    // Only two test addresses: bit 14 tells them apart
    check({23'h0, pc_t, cs_n}, a[14] ? 32'h153 : 32'h063, "decoder outputs");
    check({24'h0, pb_dir}, (m == MODE_NMUX16) ? 32'h0 : 32'ha5, "port b dir");
  endtask
  // Chip select input and byte high enable on a muxed 16-bit read
  task automatic opt_cycle;
    mode = MODE_MUX16;
    pol = 1'b0;
    cs_en = 1'b1;
    reg_wr(REG_CTRL, 32'h1 | (32'h1 << CTRL_CHIPSEL_BIT) | (32'h1 << CTRL_BYTEHI_BIT));
    #1 check({24'h0, cs_n}, 32'hff, "idle deselect");
    reg_wr(REG_ADDR, 32'hc1234);
    reg_wr(REG_CMD, 32'h2);
    #1 check({31'h0, bhe_n}, 32'h0, "byte high enable");
    wait_done;
    check({12'h0, dev_addr}, 32'h41234, "address with chip select");
    reg_rd(REG_RDATA, d);
    check(d, {16'h0, 8'h12 ^ 8'hc3, 8'h34 ^ 8'h3c}, "chip select read");
    check({23'h0, bhe_n, cs_n}, 32'h1ff, "idle outputs");
  endtask
  initial begin
    repeat (2) @(posedge mclk_in);
    rst_in <= 1'b0;
    reg_rd(REG_CTRL, d);
    check(d, CTRL_RESET, "ctrl reset");
    reg_rd(REG_STATUS, d);
    check(d, 32'h0, "status reset");
    // Every mode, both directions, both strobe polarities
    for (int i = 0; i < 16; i++) begin
      xfer(i[2:1], i[3], i[0], i[1] ? 20'hfffff : 20'h5a5c3, 16'hbe01 ^ i[15:0]);
    end
    opt_cycle;
    print_verdict;
  end
endmodule
